// ==== mstp_pkg.sv ====
// constants and types shared by the MAC status, timestamp and control port block
`default_nettype none
package mstp_pkg;

  // ==========================================================================
  // time-of-day widths
  localparam int WIDE_W = 96;
  localparam int NARROW_W = 64;

  // ==========================================================================
  // control and status port layout
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] TIMEOUT_FILL = 32'h0000_0000;

  // ==========================================================================
  // lane layout
  localparam int TX_PHYS_LANES = 10;
  localparam int VL_PER_PHYS = 2;
  localparam int RX_LANES = 20;
  localparam int LANE_W = 8;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ = 125;
  localparam int READ_TIMEOUT_NS = 10000;
  // longest wait, so rounded down
  localparam int READ_TIMEOUT_CYC = (READ_TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam int TMO_W = $clog2(READ_TIMEOUT_CYC + 1);
  localparam logic [TMO_W-1:0] TMO_ZERO = '0;
  localparam logic [TMO_W-1:0] TMO_ONE = {{(TMO_W-1){1'b0}}, 1'b1};
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(READ_TIMEOUT_CYC - 1);

  // ==========================================================================
  // port sequencer states
  typedef enum logic [2:0] {
    MSTP_IDLE,
    MSTP_RD_WAIT,
    MSTP_RD_DONE,
    MSTP_WR_WAIT,
    MSTP_WR_DONE
  } mstp_state_t;

endpackage
`default_nettype wire

// ==== mstp_sync3.sv ====
// three-stage synchroniser whose output moves when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module mstp_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output var logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] q_nxt;

  // per-bit agreement filters a single-cycle disagreement after metastability
  assign agree = ~(stage2_r ^ stage3_r);
  assign q_nxt = (agree & stage3_r) | (~agree & q_r);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      stage2_r <= meta_r;
      stage3_r <= stage2_r;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule
`default_nettype wire

// ==== mstp_core.sv ====
// MAC receive timestamps, lane status, serial lane mapping and control port slave
//
// Summary of operation
// - valid receive timestamp presented in the same cycle as receive start-of-packet
// - wide stamp carries V2 time of reception for every packet
// - narrow stamp carries 64-bit time of day of reception
// - wide valid flag high exactly when the wide stamp is valid
// - narrow valid flag high whenever the narrow stamp is valid
// - each stamp and flag is tied to zero when its format is disabled
// - receive ready only while every receive lane is aligned
// - transmit stable only while every transmit lane is aligned
// - virtual lanes zero and one travel on physical lane zero
// - control port is non-pipelined with variable read latency
// - control port runs on sys_clk, cleared by synchronous reset
// - 16-bit address, 32-bit write and read data, separate strobes
// - wait-request high while the port cannot accept or answer
// - read-data-valid marks the cycle read data holds the result
// - fixed counter raises read timeout when read data never arrives
// - timeout long enough to fire only on error accesses
// - wait-request held through a read, dropped with read-data-valid or with the read timeout
`timescale 1ns/10ps
`default_nettype none
module mstp_core
  import mstp_pkg::*;
#(
  parameter bit EN_WIDE = 1'b1,
  parameter bit EN_NARROW = 1'b1,
  parameter int PHYS_LANES = TX_PHYS_LANES,
  parameter int RX_LANE_COUNT = RX_LANES,
  parameter int LANE_WIDTH = LANE_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic status_reset,
  input wire logic rx_sop_in,
  input wire logic rx_ptp_in,
  input wire logic [WIDE_W-1:0] tod_wide_now,
  input wire logic [NARROW_W-1:0] tod_narrow_now,
  output var logic rx_sop_out,
  output var logic rx_ptp_out,
  output var logic [WIDE_W-1:0] rx_stamp_wide_value,
  output var logic rx_stamp_wide_ok,
  output var logic [NARROW_W-1:0] rx_stamp_narrow_value,
  output var logic rx_stamp_narrow_ok,
  input wire logic [RX_LANE_COUNT-1:0] rx_lane_aligned,
  input wire logic [PHYS_LANES-1:0] tx_lane_aligned,
  output var logic rx_pcs_ready,
  output var logic tx_lanes_stable,
  input wire logic [PHYS_LANES*VL_PER_PHYS*LANE_WIDTH-1:0] tx_vl_data,
  output var logic [PHYS_LANES*LANE_WIDTH-1:0] tx_serial_word,
  input wire logic [ADDR_W-1:0] status_addr,
  input wire logic status_read,
  input wire logic status_write,
  input wire logic [DATA_W-1:0] status_writedata,
  output var logic [DATA_W-1:0] status_readdata,
  output var logic status_readdata_valid,
  output var logic status_waitrequest,
  output var logic status_read_timeout,
  output var logic [ADDR_W-1:0] csr_bank_addr,
  output var logic [DATA_W-1:0] csr_bank_wdata,
  output var logic csr_bank_read,
  output var logic csr_bank_write,
  input wire logic [DATA_W-1:0] csr_bank_rdata,
  input wire logic csr_bank_rvalid,
  input wire logic csr_bank_wack
);

  localparam int VL_COUNT = PHYS_LANES * VL_PER_PHYS;

  // ==========================================================================
  // receive timestamps
  // the stamp is caught with the start-of-packet, so both leave on one edge
  logic sop_r;
  logic ptp_r;
  logic [WIDE_W-1:0] wide_r;
  logic [NARROW_W-1:0] narrow_r;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sop_r <= 1'b0;
      ptp_r <= 1'b0;
    end else begin
      sop_r <= rx_sop_in;
      ptp_r <= rx_sop_in & rx_ptp_in;
    end
  end

  // stamps taken on every packet, not only timing packets
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wide_r <= '0;
      narrow_r <= '0;
    end else if (rx_sop_in) begin
      wide_r <= tod_wide_now;
      narrow_r <= tod_narrow_now;
    end
  end

  assign rx_sop_out = sop_r;
  assign rx_ptp_out = ptp_r;

  // a disabled format is tied off; the ports stay so one top fits all builds
  generate
    if (EN_WIDE) begin : g_wide
      assign rx_stamp_wide_value = wide_r;
      assign rx_stamp_wide_ok = sop_r;
    end else begin : g_no_wide
      assign rx_stamp_wide_value = '0;
      assign rx_stamp_wide_ok = 1'b0;
    end
    if (EN_NARROW) begin : g_narrow
      assign rx_stamp_narrow_value = narrow_r;
      assign rx_stamp_narrow_ok = sop_r;
    end else begin : g_no_narrow
      assign rx_stamp_narrow_value = '0;
      assign rx_stamp_narrow_ok = 1'b0;
    end
  endgenerate

  // ==========================================================================
  // lane status
  // alignment flags come from the transceiver clocks, hence the synchronisers
  logic [RX_LANE_COUNT-1:0] rx_align_s;
  logic [PHYS_LANES-1:0] tx_align_s;
  logic rx_ready_r;
  logic tx_stable_r;

  mstp_sync3 #(
    .WIDTH(RX_LANE_COUNT)
  ) u_rx_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .d(rx_lane_aligned),
    .q(rx_align_s)
  );

  mstp_sync3 #(
    .WIDTH(PHYS_LANES)
  ) u_tx_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .d(tx_lane_aligned),
    .q(tx_align_s)
  );

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rx_ready_r <= 1'b0;
      tx_stable_r <= 1'b0;
    end else begin
      rx_ready_r <= &rx_align_s;
      tx_stable_r <= &tx_align_s;
    end
  end

  assign rx_pcs_ready = rx_ready_r;
  assign tx_lanes_stable = tx_stable_r;

  // ==========================================================================
  // virtual lane to physical lane mapping
  // two virtual lanes share each physical lane, alternating word by word
  function automatic logic [LANE_WIDTH-1:0] vl_word(
    input logic [VL_COUNT*LANE_WIDTH-1:0] bus,
    input int idx
  );
    vl_word = bus[idx*LANE_WIDTH +: LANE_WIDTH];
  endfunction

  logic vl_phase_r;
  logic [PHYS_LANES*LANE_WIDTH-1:0] tx_word_r;
  logic [PHYS_LANES*LANE_WIDTH-1:0] tx_word_nxt;

  generate
    for (genvar k = 0; k < PHYS_LANES; k++) begin : g_vl
      assign tx_word_nxt[k*LANE_WIDTH +: LANE_WIDTH] = vl_phase_r ?
        vl_word(tx_vl_data, VL_PER_PHYS * k + 1) :
        vl_word(tx_vl_data, VL_PER_PHYS * k);
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      vl_phase_r <= 1'b0;
      tx_word_r <= '0;
    end else begin
      vl_phase_r <= ~vl_phase_r;
      tx_word_r <= tx_word_nxt;
    end
  end

  assign tx_serial_word = tx_word_r;

  // ==========================================================================
  // control and status port sequencer
  // one access at a time: a second read cannot be queued behind the first
  mstp_state_t state_r;
  mstp_state_t state_nxt;
  logic [TMO_W-1:0] tmo_r;
  logic [TMO_W-1:0] tmo_nxt;
  logic tmo_hit;
  logic take_rd;
  logic take_wr;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic rvalid_r;
  logic timeout_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic bank_rd_r;
  logic bank_wr_r;

  // read has priority if a master wrongly raises both strobes
  assign take_rd = (state_r == MSTP_IDLE) && status_read;
  assign take_wr = (state_r == MSTP_IDLE) && status_write && !status_read;
  assign tmo_hit = (tmo_r == TMO_LAST);
  assign tmo_nxt = ((state_r == MSTP_RD_WAIT) || (state_r == MSTP_WR_WAIT)) ?
    tmo_r + TMO_ONE : TMO_ZERO;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MSTP_IDLE: begin
        if (take_rd) begin
          state_nxt = MSTP_RD_WAIT;
        end else if (take_wr) begin
          state_nxt = MSTP_WR_WAIT;
        end
      end
      MSTP_RD_WAIT: begin
        if (csr_bank_rvalid || tmo_hit) begin
          state_nxt = MSTP_RD_DONE;
        end
      end
      MSTP_WR_WAIT: begin
        if (csr_bank_wack || tmo_hit) begin
          state_nxt = MSTP_WR_DONE;
        end
      end
      MSTP_RD_DONE: state_nxt = MSTP_IDLE;
      MSTP_WR_DONE: state_nxt = MSTP_IDLE;
      default: state_nxt = MSTP_IDLE;
    endcase
  end

  assign rdata_nxt = csr_bank_rvalid ? csr_bank_rdata : TIMEOUT_FILL;

  // status_reset is the port's own synchronous clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= MSTP_IDLE;
      tmo_r <= TMO_ZERO;
    end else if (status_reset) begin
      state_r <= MSTP_IDLE;
      tmo_r <= TMO_ZERO;
    end else begin
      state_r <= state_nxt;
      tmo_r <= tmo_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_r <= RDATA_RESET;
      rvalid_r <= 1'b0;
      timeout_r <= 1'b0;
    end else if (status_reset) begin
      rdata_r <= RDATA_RESET;
      rvalid_r <= 1'b0;
      timeout_r <= 1'b0;
    end else begin
      rvalid_r <= (state_r == MSTP_RD_WAIT) && csr_bank_rvalid;
      timeout_r <= (state_r == MSTP_RD_WAIT) && !csr_bank_rvalid && tmo_hit;
      if (state_r == MSTP_RD_WAIT && (csr_bank_rvalid || tmo_hit)) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // request toward the register bank, launched once per accepted command
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      addr_r <= '0;
      wdata_r <= '0;
      bank_rd_r <= 1'b0;
      bank_wr_r <= 1'b0;
    end else if (status_reset) begin
      bank_rd_r <= 1'b0;
      bank_wr_r <= 1'b0;
    end else begin
      bank_rd_r <= take_rd;
      bank_wr_r <= take_wr;
      if (take_rd || take_wr) begin
        addr_r <= status_addr;
        wdata_r <= status_writedata;
      end
    end
  end

  assign csr_bank_addr = addr_r;
  assign csr_bank_wdata = wdata_r;
  assign csr_bank_read = bank_rd_r;
  assign csr_bank_write = bank_wr_r;
  assign status_readdata = rdata_r;
  assign status_readdata_valid = rvalid_r;
  assign status_read_timeout = timeout_r;
  // the master holds its command until this drops in a done state
  assign status_waitrequest = !((state_r == MSTP_RD_DONE) ||
    (state_r == MSTP_WR_DONE));

  // ==========================================================================
  // assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  sequence rd_accept_s;
    take_rd;
  endsequence
  sequence rd_answer_s;
    (state_r == MSTP_RD_WAIT) && csr_bank_rvalid && !status_reset;
  endsequence
  generate
    if (EN_WIDE) begin : g_wide_chk
      wide_sop_align_a: assert property (rx_sop_in |=> rx_stamp_wide_ok && rx_sop_out)
        else $error("wide stamp valid missed start of packet");
      wide_value_a: assert property (rx_sop_in |=>
        rx_stamp_wide_value == $past(tod_wide_now))
        else $error("wide stamp not the time of reception");
      wide_ok_exact_a: assert property (rx_stamp_wide_ok == $past(rx_sop_in))
        else $error("wide stamp valid outside a packet start");
    end
    if (EN_NARROW) begin : g_narrow_chk
      narrow_value_a: assert property (rx_sop_in |=>
        rx_stamp_narrow_value == $past(tod_narrow_now))
        else $error("narrow stamp not the time of reception");
      narrow_ok_a: assert property (rx_stamp_narrow_ok == $past(rx_sop_in))
        else $error("narrow stamp valid wrong");
    end
  endgenerate

  rx_ready_gate_a: assert property (!(&rx_align_s) |=> !rx_pcs_ready)
    else $error("receive ready with a lane unaligned");
  tx_stable_gate_a: assert property (!(&tx_align_s) |=> !tx_lanes_stable)
    else $error("transmit stable with a lane unaligned");
  lane_zero_map_a: assert property (##1 tx_serial_word[LANE_WIDTH-1:0] ==
    ($past(vl_phase_r) ? $past(tx_vl_data[2*LANE_WIDTH-1:LANE_WIDTH]) :
    $past(tx_vl_data[LANE_WIDTH-1:0])))
    else $error("physical lane zero not fed from virtual lanes zero and one");
  rd_hold_wait_a: assert property (rd_accept_s |=> status_waitrequest throughout
    (state_r == MSTP_RD_WAIT)[*1])
    else $error("wait-request dropped during a read");
  rd_answer_a: assert property (rd_answer_s |=> status_readdata_valid &&
    !status_waitrequest && status_readdata == $past(csr_bank_rdata))
    else $error("read answer not presented with valid");
  valid_release_a: assert property (status_readdata_valid |-> !status_waitrequest)
    else $error("read-data-valid without wait-request release");
  tmo_bound_a: assert property ((state_r == MSTP_RD_WAIT) |-> tmo_r <= TMO_LAST)
    else $error("read wait ran past the timeout count");
  tmo_release_a: assert property (status_read_timeout |-> !status_waitrequest &&
    !status_readdata_valid)
    else $error("timed-out read did not release the master");
  srst_clear_a: assert property (status_reset |=> (state_r == MSTP_IDLE) &&
    !status_readdata_valid && !status_read_timeout)
    else $error("status reset did not clear the port");
  busy_wait_a: assert property ((state_r == MSTP_WR_WAIT) |-> status_waitrequest)
    else $error("wait-request low while busy");

endmodule
`default_nettype wire

// ==== mstp_bank_model.sv ====
// register bank stand-in that answers the control port after a set delay
`timescale 1ns/10ps
`default_nettype none
module mstp_bank_model
  import mstp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [ADDR_W-1:0] csr_bank_addr,
  input wire logic [DATA_W-1:0] csr_bank_wdata,
  input wire logic csr_bank_read,
  input wire logic csr_bank_write,
  input wire logic [7:0] lat,
  output var logic [DATA_W-1:0] csr_bank_rdata,
  output var logic csr_bank_rvalid,
  output var logic csr_bank_wack
);
  logic [DATA_W-1:0] mem [64];
  logic [ADDR_W-1:0] a;
  logic w;
  initial begin
    csr_bank_rdata = 32'hA5A5_5A5A;
    csr_bank_rvalid = 1'b0;
    csr_bank_wack = 1'b0;
  end
  // ==========================================================================
  // answer
  // top address bit set means unmapped: no answer ever comes
  always @(posedge sys_clk) begin
    #1;
    a = csr_bank_addr;
    w = csr_bank_write;
    if ((csr_bank_read || w) && !a[15]) begin
      if (w) mem[a[5:0]] = csr_bank_wdata;
      repeat (lat) begin
        @(posedge sys_clk);
        #1;
      end
      csr_bank_rdata = w ? ~csr_bank_rdata : mem[a[5:0]];
      csr_bank_rvalid = !w;
      csr_bank_wack = w;
      @(posedge sys_clk);
      #1;
      csr_bank_rvalid = 1'b0;
      csr_bank_wack = 1'b0;
      // stale data is not left on the lines
      csr_bank_rdata = ~csr_bank_rdata;
    end
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the status, timestamp and control port block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import mstp_pkg::*;
  localparam int SW = TX_PHYS_LANES * LANE_W;
  logic sys_clk, reset, status_reset, rx_sop_in, rx_ptp_in, rx_sop_out, rx_ptp_out;
  logic [WIDE_W-1:0] tod_wide_now, rx_stamp_wide_value, e_wide;
  logic [NARROW_W-1:0] tod_narrow_now, rx_stamp_narrow_value, e_nar;
  logic rx_stamp_wide_ok, rx_stamp_narrow_ok, rx_pcs_ready, tx_lanes_stable;
  logic [RX_LANES-1:0] rx_lane_aligned;
  logic [TX_PHYS_LANES-1:0] tx_lane_aligned;
  logic [2*SW-1:0] tx_vl_data;
  logic [SW-1:0] tx_serial_word, e_word;
  logic [ADDR_W-1:0] status_addr, csr_bank_addr;
  logic status_read, status_write, status_readdata_valid, status_waitrequest;
  logic [DATA_W-1:0] status_writedata, status_readdata, csr_bank_wdata, csr_bank_rdata;
  logic status_read_timeout, csr_bank_read, csr_bank_write, csr_bank_rvalid, csr_bank_wack;
  logic [7:0] lat;
  logic e_sop, e_ptp;
  int edge_n, n_mismatch, total_checks;

  // both stamp formats enabled so every stamp port carries a stamp
  mstp_core mstp_core_inst (.*);
  mstp_bank_model mstp_bank_model_inst (.*);

  // ==========================================================================
  // clock, watchdog, verdict
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    close_out();
  end
  task automatic close_out();
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [WIDE_W-1:0] got, input logic [WIDE_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ==========================================================================
  // free-running random traffic and its reference model
  // quiet while reset, so the first sampled history after release is idle
  always @(posedge sys_clk) begin
    rx_sop_in <= !reset && 1'($urandom_range(0, 1));
    rx_ptp_in <= 1'($urandom_range(0, 1));
    tod_wide_now <= {$urandom, $urandom, $urandom};
    tod_narrow_now <= {$urandom, $urandom};
    tx_vl_data <= reset ? '0 : {$urandom, $urandom, $urandom, $urandom, $urandom};
  end
  always @(posedge sys_clk) begin
    if (reset) begin
      e_sop <= 1'b0;
      e_ptp <= 1'b0;
      e_wide <= '0;
      e_nar <= '0;
      edge_n <= 0;
    end else begin
      e_sop <= rx_sop_in;
      e_ptp <= rx_sop_in & rx_ptp_in;
      if (rx_sop_in) begin
        e_wide <= tod_wide_now;
        e_nar <= tod_narrow_now;
      end
      for (int k = 0; k < TX_PHYS_LANES; k++)
        e_word[k*LANE_W +: LANE_W] <= tx_vl_data[(2*k+edge_n%2)*LANE_W +: LANE_W];
      edge_n <= edge_n + 1;
    end
  end
  // compared mid-cycle, where every output has settled
  always @(negedge sys_clk) begin
    if (!reset && edge_n > 0) begin
      chk(rx_sop_out, e_sop);
      chk(rx_ptp_out, e_ptp);
      chk(rx_stamp_wide_value, e_wide);
      chk(rx_stamp_narrow_value, e_nar);
      chk(rx_stamp_wide_ok, e_sop);
      chk(rx_stamp_narrow_ok, e_sop);
      chk(tx_serial_word, e_word);
    end
  end

  // ==========================================================================
  // control port master: hold the command until waitrequest is seen low
  task automatic bus_op(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
      output logic v, output logic t, output int n);
    n = 0;
    status_addr <= a;
    status_writedata <= d;
    status_read <= !wr;
    status_write <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (status_waitrequest !== 1'b0 && n < 1400);
    q = status_readdata;
    v = status_readdata_valid;
    t = status_read_timeout;
    status_read <= 1'b0;
    status_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  initial begin
    logic [DATA_W-1:0] q, d;
    logic [ADDR_W-1:0] a;
    logic v, t;
    int n;
    reset = 1'b1;
    status_reset = 1'b0;
    rx_sop_in = 1'b0;
    rx_ptp_in = 1'b0;
    tod_wide_now = '0;
    tod_narrow_now = '0;
    tx_vl_data = '0;
    rx_lane_aligned = '0;
    tx_lane_aligned = '0;
    status_addr = 16'h0000;
    status_read = 1'b0;
    status_write = 1'b0;
    status_writedata = 32'h0000_0000;
    lat = 8'h00;
    n_mismatch = 0;
    total_checks = 0;
    void'($urandom(32'h1196));
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk(status_waitrequest, 1'b1);
    // lane status: all aligned, then one rx lane lost, then one tx lane lost
    rx_lane_aligned <= '1;
    tx_lane_aligned <= '1;
    repeat (10) @(posedge sys_clk);
    chk(rx_pcs_ready, 1'b1);
    chk(tx_lanes_stable, 1'b1);
    rx_lane_aligned[$urandom_range(0, RX_LANES-1)] <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk(rx_pcs_ready, 1'b0);
    chk(tx_lanes_stable, 1'b1);
    rx_lane_aligned <= '1;
    tx_lane_aligned[$urandom_range(0, TX_PHYS_LANES-1)] <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk(rx_pcs_ready, 1'b1);
    chk(tx_lanes_stable, 1'b0);
    // write then read back under a growing bank delay
    a = 16'h0000;
    d = 32'h0000_0000;
    for (int i = 0; i < 6; i++) begin
      lat <= 8'(i * i);
      a = 16'($urandom_range(0, 63));
      d = $urandom;
      bus_op(1'b1, a, d, q, v, t, n);
      chk(n, 3 + i * i);
      bus_op(1'b0, a, 32'h0000_0000, q, v, t, n);
      chk(n, 3 + i * i);
      chk(q, d);
      chk(v, 1'b1);
      chk(t, 1'b0);
    end
    // unmapped read must time out and free the port
    bus_op(1'b0, 16'h8000 | a, 32'h0000_0000, q, v, t, n);
    chk(t, 1'b1);
    chk(v, 1'b0);
    chk(q, TIMEOUT_FILL);
    chk(n >= READ_TIMEOUT_CYC && n <= READ_TIMEOUT_CYC + 3, 1'b1);
    // status reset in mid-read abandons it cleanly
    status_addr <= 16'h8000;
    status_read <= 1'b1;
    repeat (5) @(posedge sys_clk);
    status_reset <= 1'b1;
    status_read <= 1'b0;
    @(posedge sys_clk);
    status_reset <= 1'b0;
    @(posedge sys_clk);
    chk(status_waitrequest, 1'b1);
    n = 0;
    repeat (1300) begin
      @(posedge sys_clk);
      if (status_read_timeout !== 1'b0 || status_readdata_valid !== 1'b0) n++;
    end
    chk(n, 0);
    bus_op(1'b0, a, 32'h0000_0000, q, v, t, n);
    chk(q, d);
    close_out();
  end
endmodule
`default_nettype wire
